// file: common/pio_pkg.sv
// shared constants and types of the programmed i/o target
package pio_pkg;

  // stream geometry
  localparam int DATA_W = 128;
  localparam int KEEP_W = DATA_W / 32;
  localparam int DW_W = 32;
  localparam int LANE_W = 2;

  // target memory geometry
  localparam int NUM_REGIONS = 4;
  localparam int REGION_BYTES = 2048;
  localparam int REGION_DW_W = 9;
  localparam int RAM_WORDS = REGION_BYTES / (DATA_W / 8);
  localparam int FIFO_DEPTH = 16;

  // completer request descriptor fields
  localparam int DESC_ADDR_LSB = 2;
  localparam int DESC_OFS_W = 12;
  localparam int DESC_DWC_LSB = 64;
  localparam int DESC_DWC_W = 11;
  localparam int DESC_TYPE_LSB = 75;
  localparam int DESC_REQID_LSB = 80;
  localparam int DESC_TAG_LSB = 96;
  localparam int DESC_BAR_LSB = 112;

  // request types
  localparam logic [3:0] REQ_MEM_RD = 4'h0;
  localparam logic [3:0] REQ_MEM_WR = 4'h1;
  localparam logic [3:0] REQ_IO_RD = 4'h2;
  localparam logic [3:0] REQ_IO_WR = 4'h3;

  // bar identifiers
  localparam logic [2:0] BAR_MEM32 = 3'h0;
  localparam logic [2:0] BAR_MEM64 = 3'h1;
  localparam logic [2:0] BAR_ROM = 3'h6;
  localparam logic [2:0] BAR0_ID = 3'h1;

  // region indices: io_region_ram, mem32_region_ram, mem64_region_ram,
  // rom_region_ram
  localparam logic [1:0] REGION_IO = 2'h0;
  localparam logic [1:0] REGION_MEM32 = 2'h1;
  localparam logic [1:0] REGION_MEM64 = 2'h2;
  localparam logic [1:0] REGION_ROM = 2'h3;

  // trigger writes
  localparam logic [11:0] TRIG_MRD_OFS = 12'h0ea8;
  localparam logic [11:0] TRIG_INT_OFS = 12'h0eec;
  localparam logic [31:0] TRIG_MRD_DATA = 32'haaaa_bbbb;
  localparam logic [31:0] TRIG_LEGACY_DATA = 32'hcccc_dddd;
  localparam logic [31:0] TRIG_MSI_DATA = 32'heeee_ffff;
  localparam logic [31:0] TRIG_MSIX_DATA = 32'hdead_beef;

  // completion descriptor fields
  localparam int CPL_LADDR_LSB = 0;
  localparam int CPL_BC_LSB = 16;
  localparam int CPL_DWC_LSB = 32;
  localparam int CPL_STAT_LSB = 43;
  localparam int CPL_REQID_LSB = 48;
  localparam int CPL_TAG_LSB = 64;
  localparam logic [2:0] CPL_STAT_SC = 3'h0;
  localparam logic [3:0] CPL_HDR_KEEP = 4'h7;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [KEEP_W-1:0] keep;
    logic last;
  } pio_beat_t;

  localparam int BEAT_W = $bits(pio_beat_t);

endpackage : pio_pkg

// file: rtl/pio_target.sv
// programmed i/o target: request decode, region rams, completion fifo
module pio_beat_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import pio_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [CW-1:0] count;
    logic avail;
  } pio_fifo_state_t;

  pio_fifo_state_t fifo_reg;
  pio_fifo_state_t fifo_next;
  logic [W-1:0] store [DEPTH];
  logic do_push;
  logic do_pop;

  assign in_ready = fifo_reg.count != CW'(DEPTH);
  assign out_valid = fifo_reg.avail;
  assign out_data = store[fifo_reg.rd];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    fifo_next = fifo_reg;
    if (do_push) begin
      fifo_next.wr = AW'(fifo_reg.wr + 1'b1);
    end
    if (do_pop) begin
      fifo_next.rd = AW'(fifo_reg.rd + 1'b1);
    end
    if (do_push && !do_pop) begin
      fifo_next.count = CW'(fifo_reg.count + 1'b1);
    end else if (do_pop && !do_push) begin
      fifo_next.count = CW'(fifo_reg.count - 1'b1);
    end
    // valid leaves a flop, not a compare, so the stream sees a clean level
    fifo_next.avail = fifo_next.count != '0;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fifo_reg <= '0;
    end else begin
      fifo_reg <= fifo_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (do_push) begin
      store[fifo_reg.wr] <= in_data;
    end
  end
endmodule : pio_beat_fifo

module pio_target #(
  parameter bit ADDR_ALIGNED = 1'b1,
  parameter bit IO_ENABLE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pio_pkg::pio_beat_t cq_beat,
  input wire logic cq_tvalid,
  output logic request_stream_ready,
  output pio_pkg::pio_beat_t cc_beat,
  output logic cc_tvalid,
  input wire logic cc_tready,
  output logic mem_read_req,
  output logic legacy_int_req,
  output logic msi_req,
  output logic msix_req
);
  import pio_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_WDATA,
    ST_WLANE,
    ST_DRAIN,
    ST_CHDR,
    ST_RADDR,
    ST_RCAP,
    ST_CPUSH,
    ST_CWAIT
  } pio_state_t;

  typedef struct packed {
    pio_state_t st;
    logic rdy;
    logic [1:0] region;
    logic [REGION_DW_W-1:0] cur;
    logic [DESC_DWC_W-1:0] rem;
    logic [DESC_DWC_W-1:0] dwc;
    logic [LANE_W-1:0] lane;
    logic [3:0] rtype;
    logic [2:0] bar;
    logic [DESC_OFS_W-1:0] ofs;
    logic [15:0] req_id;
    logic [7:0] tag;
    logic first;
    pio_beat_t beat;
    logic mrd;
    logic legacy;
    logic msi;
    logic msix;
  } pio_ctl_t;

  pio_ctl_t ctl_reg;
  pio_ctl_t ctl_next;

  logic [DATA_W-1:0] rd_word [NUM_REGIONS];
  logic [DW_W-1:0] rd_dw;
  logic [DW_W-1:0] wr_dw;
  logic wr_go;
  logic push;
  pio_beat_t push_beat;
  logic fifo_in_ready;
  pio_beat_t fifo_out;
  logic fifo_out_valid;
  logic cpl_sent;

  // {accept, region}; anything not matched is swallowed silently
  function automatic logic [2:0] route_req(
    input logic [3:0] t,
    input logic [2:0] bar,
    input logic [DESC_DWC_W-1:0] dwc
  );
    logic is_io;
    logic is_mem;
    route_req = '0;
    is_io = (t == REQ_IO_RD) || (t == REQ_IO_WR);
    is_mem = (t == REQ_MEM_RD) || (t == REQ_MEM_WR);
    if (ADDR_ALIGNED) begin
      if (dwc == DESC_DWC_W'(1)) begin
        if (is_io && IO_ENABLE) begin
          route_req = {1'b1, REGION_IO};
        end else if (is_mem) begin
          unique case (bar)
            BAR_MEM32: route_req = {1'b1, REGION_MEM32};
            BAR_MEM64: route_req = {1'b1, REGION_MEM64};
            BAR_ROM: route_req = {1'b1, REGION_ROM};
            default: route_req = '0;
          endcase
        end
      end
    end else if (is_mem && bar == BAR_MEM64) begin
      route_req = {1'b1, REGION_MEM64};
    end
  endfunction : route_req

  function automatic logic is_write(input logic [3:0] t);
    is_write = (t == REQ_MEM_WR) || (t == REQ_IO_WR);
  endfunction : is_write

  // each region is a separate single-port ram, one stream word wide
  for (genvar g = 0; g < NUM_REGIONS; g++) begin : g_region
    logic [DATA_W-1:0] region_ram [RAM_WORDS];
    always_ff @(posedge sys_clk) begin
      if (wr_go && ctl_reg.region == 2'(g)) begin
        region_ram[ctl_reg.cur[REGION_DW_W-1:LANE_W]]
          [{ctl_reg.cur[LANE_W-1:0], 5'h00} +: DW_W] <= wr_dw;
      end
      rd_word[g] <= region_ram[ctl_reg.cur[REGION_DW_W-1:LANE_W]];
    end
  end

  assign rd_dw = rd_word[ctl_reg.region][{ctl_reg.cur[LANE_W-1:0], 5'h00}
    +: DW_W];
  assign wr_dw = ctl_reg.beat.data[{ctl_reg.lane, 5'h00} +: DW_W];
  assign cpl_sent = fifo_out_valid && cc_tready && fifo_out.last;

  always_comb begin
    logic [DATA_W-1:0] d;
    logic [2:0] dec;
    d = cq_beat.data;
    dec = '0;
    ctl_next = ctl_reg;
    ctl_next.mrd = 1'b0;
    ctl_next.legacy = 1'b0;
    ctl_next.msi = 1'b0;
    ctl_next.msix = 1'b0;
    push = 1'b0;
    push_beat = '0;
    wr_go = 1'b0;
    unique case (ctl_reg.st)
      ST_IDLE: begin
        if (cq_tvalid && ctl_reg.rdy) begin
          ctl_next.rtype = d[DESC_TYPE_LSB +: 4];
          ctl_next.bar = d[DESC_BAR_LSB +: 3];
          ctl_next.dwc = d[DESC_DWC_LSB +: DESC_DWC_W];
          ctl_next.rem = d[DESC_DWC_LSB +: DESC_DWC_W];
          ctl_next.ofs = d[DESC_OFS_W-1:0];
          ctl_next.cur = d[DESC_ADDR_LSB +: REGION_DW_W];
          ctl_next.req_id = d[DESC_REQID_LSB +: 16];
          ctl_next.tag = d[DESC_TAG_LSB +: 8];
          ctl_next.first = 1'b1;
          ctl_next.lane = '0;
          ctl_next.beat = '0;
          dec = route_req(ctl_next.rtype, ctl_next.bar, ctl_next.dwc);
          ctl_next.region = dec[1:0];
          if (!dec[2]) begin
            ctl_next.st = cq_beat.last ? ST_IDLE : ST_DRAIN;
          end else if (is_write(ctl_next.rtype)) begin
            ctl_next.st = ST_WDATA;
          end else begin
            ctl_next.st = ST_CHDR;
          end
        end
      end
      ST_WDATA: begin
        if (cq_tvalid && ctl_reg.rdy) begin
          ctl_next.beat = cq_beat;
          ctl_next.lane = '0;
          ctl_next.st = ST_WLANE;
        end
      end
      ST_WLANE: begin
        // one dword per cycle keeps the ram a plain single-lane writer
        if (ctl_reg.beat.keep[ctl_reg.lane] && ctl_reg.rem != '0) begin
          wr_go = 1'b1;
          ctl_next.rem = DESC_DWC_W'(ctl_reg.rem - 1'b1);
          ctl_next.cur = REGION_DW_W'(ctl_reg.cur + 1'b1);
          ctl_next.first = 1'b0;
          if (ctl_reg.first && ctl_reg.bar == BAR0_ID) begin
            ctl_next.mrd = ctl_reg.ofs == TRIG_MRD_OFS &&
              wr_dw == TRIG_MRD_DATA;
            ctl_next.legacy = ctl_reg.ofs == TRIG_INT_OFS &&
              wr_dw == TRIG_LEGACY_DATA;
            ctl_next.msi = ctl_reg.ofs == TRIG_INT_OFS &&
              wr_dw == TRIG_MSI_DATA;
            ctl_next.msix = ctl_reg.ofs == TRIG_INT_OFS &&
              wr_dw == TRIG_MSIX_DATA;
          end
        end
        ctl_next.lane = LANE_W'(ctl_reg.lane + 1'b1);
        if (ctl_reg.lane == LANE_W'(KEEP_W - 1) || ctl_next.rem == '0) begin
          if (!ctl_reg.beat.last) begin
            ctl_next.st = (ctl_next.rem == '0) ? ST_DRAIN : ST_WDATA;
          end else if (ctl_reg.rtype == REQ_IO_WR) begin
            ctl_next.st = ST_CHDR;
          end else begin
            ctl_next.st = ST_IDLE;
          end
        end
      end
      ST_DRAIN: begin
        if (cq_tvalid && ctl_reg.rdy && cq_beat.last) begin
          ctl_next.st = ST_IDLE;
        end
      end
      ST_CHDR: begin
        push = 1'b1;
        push_beat.keep = CPL_HDR_KEEP;
        push_beat.data[CPL_LADDR_LSB +: 7] = ctl_reg.ofs[6:0];
        push_beat.data[CPL_STAT_LSB +: 3] = CPL_STAT_SC;
        push_beat.data[CPL_REQID_LSB +: 16] = ctl_reg.req_id;
        push_beat.data[CPL_TAG_LSB +: 8] = ctl_reg.tag;
        if (ctl_reg.rtype == REQ_IO_WR) begin
          push_beat.data[CPL_BC_LSB +: 13] = 13'h0004;
          push_beat.last = 1'b1;
        end else begin
          push_beat.data[CPL_BC_LSB +: 13] = {ctl_reg.dwc, 2'h0};
          push_beat.data[CPL_DWC_LSB +: DESC_DWC_W] = ctl_reg.dwc;
        end
        if (fifo_in_ready) begin
          ctl_next.lane = '0;
          ctl_next.beat = '0;
          ctl_next.st = (ctl_reg.rtype == REQ_IO_WR) ? ST_CWAIT : ST_RADDR;
        end
      end
      ST_RADDR: begin
        ctl_next.st = ST_RCAP;
      end
      ST_RCAP: begin
        ctl_next.beat.data[{ctl_reg.lane, 5'h00} +: DW_W] = rd_dw;
        ctl_next.beat.keep[ctl_reg.lane] = 1'b1;
        ctl_next.rem = DESC_DWC_W'(ctl_reg.rem - 1'b1);
        ctl_next.cur = REGION_DW_W'(ctl_reg.cur + 1'b1);
        ctl_next.lane = LANE_W'(ctl_reg.lane + 1'b1);
        if (ctl_reg.lane == LANE_W'(KEEP_W - 1) ||
            ctl_reg.rem == DESC_DWC_W'(1)) begin
          ctl_next.st = ST_CPUSH;
        end else begin
          ctl_next.st = ST_RADDR;
        end
      end
      ST_CPUSH: begin
        push = 1'b1;
        push_beat = ctl_reg.beat;
        push_beat.last = ctl_reg.rem == '0;
        if (fifo_in_ready) begin
          ctl_next.beat = '0;
          ctl_next.lane = '0;
          ctl_next.st = (ctl_reg.rem == '0) ? ST_CWAIT : ST_RADDR;
        end
      end
      ST_CWAIT: begin
        if (cpl_sent) begin
          ctl_next.st = ST_IDLE;
        end
      end
    endcase
    // accepting only while idle, collecting or draining keeps the ram ports private
    ctl_next.rdy = ctl_next.st == ST_IDLE || ctl_next.st == ST_WDATA ||
      ctl_next.st == ST_DRAIN;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_reg <= '0;
    end else begin
      ctl_reg <= ctl_next;
    end
  end

  pio_beat_fifo #(
    .W(BEAT_W),
    .DEPTH(FIFO_DEPTH)
  ) pio_beat_fifo_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_data(push_beat),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(cc_tready)
  );

  assign request_stream_ready = ctl_reg.rdy;
  assign cc_beat = fifo_out;
  assign cc_tvalid = fifo_out_valid;
  assign mem_read_req = ctl_reg.mrd;
  assign legacy_int_req = ctl_reg.legacy;
  assign msi_req = ctl_reg.msi;
  assign msix_req = ctl_reg.msix;
endmodule : pio_target

// file: dv/pio_target_properties.sv
// port-level assertion checker for the programmed i/o target
module pio_target_properties #(
  parameter bit ADDR_ALIGNED = 1'b1,
  parameter bit IO_ENABLE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire pio_pkg::pio_beat_t cq_beat,
  input wire logic cq_tvalid,
  input wire logic request_stream_ready,
  input wire pio_pkg::pio_beat_t cc_beat,
  input wire logic cc_tvalid,
  input wire logic cc_tready,
  input wire logic mem_read_req,
  input wire logic legacy_int_req,
  input wire logic msi_req,
  input wire logic msix_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  logic taken, hdr, rd, rd1, in_pkt_reg, cpl_pkt_reg;
  logic [31:0] lane0;
  logic [3:0] hit;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  assign taken = cq_tvalid && request_stream_ready;
  // a header is the first beat of a completion; data keep may look alike
  assign hdr = cc_tvalid && !cpl_pkt_reg;
  assign rd = taken && !in_pkt_reg && cq_beat.last &&
    cq_beat.data[DESC_TYPE_LSB +: 4] == REQ_MEM_RD;
  assign rd1 = rd && cq_beat.data[DESC_DWC_LSB +: DESC_DWC_W] == 11'h001 &&
    cq_beat.data[DESC_BAR_LSB +: 3] ==
    (ADDR_ALIGNED ? BAR_MEM32 : BAR_MEM64);
  assign lane0 = cq_beat.data[31:0];
  // payload beats only; the trigger code sits in the first dword
  assign hit = {4{taken && in_pkt_reg}} & {lane0 == TRIG_MSIX_DATA,
    lane0 == TRIG_MSI_DATA, lane0 == TRIG_LEGACY_DATA, lane0 == TRIG_MRD_DATA};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      in_pkt_reg <= 1'b0;
      cpl_pkt_reg <= 1'b0;
    end else begin
      if (taken) begin
        in_pkt_reg <= !cq_beat.last;
      end
      if (cc_tvalid && cc_tready) begin
        cpl_pkt_reg <= !cc_beat.last;
      end
    end
  end
  AST_RD_STALL: assert property (rd1 |=> !request_stream_ready [*3])
    else $error("ready not held low after read");
  AST_CPL_BLOCKS: assert property (cc_tvalid |-> !request_stream_ready)
    else $error("request taken while completion pending");
  AST_ONE_DW: assert property (
    hdr && ADDR_ALIGNED && !IO_ENABLE |-> cc_beat.data[42:32] == 11'h001)
    else $error("completion dword count not one");
  AST_STATUS: assert property (hdr |-> cc_beat.data[45:43] == CPL_STAT_SC)
    else $error("completion status not success");
  AST_RD_ANSWER: assert property (rd1 |-> ##[2:12] hdr)
    else $error("read got no completion header");
  AST_DATA_FOLLOWS: assert property (
    hdr && cc_tready && cc_beat.data[42:32] != 11'h000 |=> ##[0:40]
    (cc_tvalid && cc_beat.last && cc_beat.keep == 4'h1))
    else $error("completion data beat missing");
  AST_MULTI_DROP: assert property (
    ADDR_ALIGNED && rd && cq_beat.data[DESC_DWC_LSB +: DESC_DWC_W] != 11'h001
    |=> !cc_tvalid [*8])
    else $error("multi dword request completed");
  AST_MRD: assert property (
    mem_read_req |-> $past(hit[0]) || $past(hit[0], 2) || $past(hit[0], 3))
    else $error("memory read trigger without cause");
  AST_LEGACY: assert property (
    legacy_int_req |-> $past(hit[1]) || $past(hit[1], 2) || $past(hit[1], 3))
    else $error("legacy interrupt without cause");
  AST_MSI: assert property (
    msi_req |-> $past(hit[2]) || $past(hit[2], 2) || $past(hit[2], 3))
    else $error("msi without cause");
  AST_MSIX: assert property (
    msix_req |-> $past(hit[3]) || $past(hit[3], 2) || $past(hit[3], 3))
    else $error("msi-x without cause");
  AST_RESET_IDLE: assert property (
    $fell(rst) |-> !cc_tvalid && !request_stream_ready && !msi_req &&
    !msix_req && !legacy_int_req && !mem_read_req)
    else $error("engine busy right after reset");
endmodule : pio_target_properties

bind pio_target pio_target_properties #(
  .ADDR_ALIGNED(ADDR_ALIGNED),
  .IO_ENABLE(IO_ENABLE)
) pio_target_properties_inst (
  .sys_clk(sys_clk),
  .rst(rst),
  .cq_beat(cq_beat),
  .cq_tvalid(cq_tvalid),
  .request_stream_ready(request_stream_ready),
  .cc_beat(cc_beat),
  .cc_tvalid(cc_tvalid),
  .cc_tready(cc_tready),
  .mem_read_req(mem_read_req),
  .legacy_int_req(legacy_int_req),
  .msi_req(msi_req),
  .msix_req(msix_req)
);

// file: dv/pio_core_sink.sv
// completion sink standing in for the core's completer stream
module pio_core_sink (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stall_en,
  output logic cc_tready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cc_tready = 1'b0;
  // the core may stall completions at any cycle, so ready is random while stall_en is set
  always @(posedge sys_clk) begin
    #1;
    cc_tready = !rst && (!stall_en || $urandom_range(0, 2) != 0);
  end
endmodule : pio_core_sink

// file: dv/pio_target_test.sv
// self-checking bench for the programmed i/o target, aligned mode
module pio_target_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pio_pkg::*;
  typedef struct packed {
    logic [3:0] keep;
    logic [31:0] val;
  } pio_note_t;
  logic sys_clk, rst, cq_tvalid, request_stream_ready, cc_tvalid, cc_tready;
  logic stall_en, mem_read_req, legacy_int_req, msi_req, msix_req;
  logic [3:0] trig;
  pio_beat_t cq_beat, cc_beat;
  pio_note_t notes[$];
  pio_note_t got;
  int miscompares, checks_done;
  int pulses[4];
  logic [31:0] wdat[3];
  logic [8:0] wdw;
  logic [7:0] cur_tag;
  logic [2:0] bars[3] = '{BAR_MEM32, BAR_MEM64, BAR_ROM};
  logic [11:0] t_ofs[4] = '{TRIG_MRD_OFS, TRIG_INT_OFS, TRIG_INT_OFS,
    TRIG_INT_OFS};
  logic [31:0] t_dat[4] = '{TRIG_MRD_DATA, TRIG_LEGACY_DATA, TRIG_MSI_DATA,
    TRIG_MSIX_DATA};

  pio_target pio_target_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .cq_beat(cq_beat),
    .cq_tvalid(cq_tvalid),
    .request_stream_ready(request_stream_ready),
    .cc_beat(cc_beat),
    .cc_tvalid(cc_tvalid),
    .cc_tready(cc_tready),
    .mem_read_req(mem_read_req),
    .legacy_int_req(legacy_int_req),
    .msi_req(msi_req),
    .msix_req(msix_req)
  );
  pio_core_sink pio_core_sink_inst (
    .sys_clk(sys_clk),
    .rst(rst),
    .stall_en(stall_en),
    .cc_tready(cc_tready)
  );

  always #25 sys_clk = ~sys_clk;
  assign trig = {msix_req, msi_req, legacy_int_req, mem_read_req};

  task automatic final_report();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  task automatic fail(input string msg);
    checks_done++;
    miscompares++;
    $display("mismatch %0t %s", $time, msg);
  endtask : fail

  task automatic check_beat(input pio_note_t exp, input pio_note_t act);
    checks_done++;
    if (act !== exp) begin
      miscompares++;
      $display("mismatch %0t beat %h expected %h", $time, act, exp);
    end
  endtask : check_beat

  task automatic check_count(input int exp, input int act);
    checks_done++;
    if (act != exp) begin
      miscompares++;
      $display("mismatch %0t pulse count %0d expected %0d", $time, act, exp);
    end
  endtask : check_count

  task automatic put(input pio_beat_t b);
    int n;
    n = 0;
    cq_beat = b;
    cq_tvalid = 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (request_stream_ready !== 1'b1 && n < 200);
    if (n >= 200) begin
      fail("request stalled");
      final_report();
    end else begin
      #1;
    end
  endtask : put

  task automatic send(input logic [2:0] bar, input logic [3:0] typ,
    input logic [11:0] dw, input logic [10:0] dwc, input logic [31:0] d);
    pio_beat_t b;
    b = '0;
    b.data[DESC_ADDR_LSB +: 12] = dw;
    b.data[DESC_DWC_LSB +: DESC_DWC_W] = dwc;
    b.data[DESC_TYPE_LSB +: 4] = typ;
    b.data[DESC_BAR_LSB +: 3] = bar;
    b.data[DESC_TAG_LSB +: 8] = cur_tag;
    b.keep = 4'hf;
    b.last = !typ[0];
    put(b);
    if (typ[0]) begin
      b = '0;
      b.data[31:0] = d;
      b.keep = 4'h1;
      b.last = 1'b1;
      put(b);
    end
    cq_tvalid = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask : send

  // a read may not follow until its completion has fully left
  task automatic drain();
    for (int n = 0; n < 300 && notes.size() != 0; n++) @(posedge sys_clk);
    if (notes.size() != 0) begin
      fail("completion missing");
      final_report();
    end else begin
      repeat (2) @(posedge sys_clk);
      #1;
    end
  endtask : drain

  task automatic read_dw(input logic [2:0] bar, input logic [11:0] dw,
    input logic [31:0] exp);
    cur_tag = 8'($urandom);
    notes.push_back({CPL_HDR_KEEP, cur_tag, 10'h000, 14'h0001});
    notes.push_back({4'h1, exp});
    send(bar, REQ_MEM_RD, dw, 11'h001, 32'h0000_0000);
    drain();
  endtask : read_dw

  always @(posedge sys_clk) begin
    if (rst === 1'b0) begin
      for (int k = 0; k < 4; k++) pulses[k] += int'(trig[k] === 1'b1);
      if (cc_tvalid === 1'b1 && cc_tready === 1'b1) begin
        got.keep = cc_beat.keep;
        got.val = (cc_beat.keep === CPL_HDR_KEEP) ?
          {cc_beat.data[CPL_TAG_LSB +: 8], 10'h000, cc_beat.data[45:32]} :
          cc_beat.data[31:0];
        if (notes.size() == 0) begin
          fail("unexpected completion");
        end else begin
          check_beat(notes.pop_front(), got);
        end
      end
    end
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    cq_beat = '0;
    cq_tvalid = 1'b0;
    stall_en = 1'b0;
    miscompares = 0;
    checks_done = 0;
    cur_tag = 8'h00;
    void'($urandom(10369));
    repeat (12) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    wdw = 9'($urandom_range(0, 255));
    for (int i = 0; i < 3; i++) begin
      wdat[i] = $urandom;
      send(bars[i], REQ_MEM_WR, {3'b000, wdw}, 11'h001, wdat[i]);
    end
    stall_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      read_dw(bars[i], {3'b000, wdw}, wdat[i]);
    end
    read_dw(BAR_MEM32, {3'b001, wdw}, wdat[0]);
    send(BAR_MEM32, REQ_MEM_RD, {3'b000, wdw}, 11'h002, '0);
    send(3'h2, REQ_MEM_RD, {3'b000, wdw}, 11'h001, '0);
    send(BAR_MEM32, REQ_IO_RD, {3'b000, wdw}, 11'h001, '0);
    drain();
    for (int i = 0; i < 4; i++) begin
      send(BAR0_ID, REQ_MEM_WR, {2'b00, t_ofs[i][11:2]}, 11'h001, t_dat[i]);
    end
    read_dw(BAR0_ID, {2'b00, TRIG_INT_OFS[11:2]}, TRIG_MSIX_DATA);
    for (int k = 0; k < 4; k++) check_count(1, pulses[k]);
    final_report();
  end
endmodule : pio_target_test
